// file: core/drive_io_pkg.sv
// Constants shared by the drive input/output status register bank.
package drive_io_pkg;
	// ==========================================================
	// Bus geometry.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Variable indices; byte address is four times the index.
	localparam logic [ADDR_W-1:0] IDX_WARN = 12'h045;
	localparam logic [ADDR_W-1:0] IDX_ANALOG = 12'h046;
	localparam logic [ADDR_W-1:0] IDX_INPUTS = 12'h047;
	localparam logic [ADDR_W-1:0] IDX_OUTPUTS = 12'h048;
	localparam logic [ADDR_W-1:0] ADDR_WARN = IDX_WARN << 2;
	localparam logic [ADDR_W-1:0] ADDR_ANALOG = IDX_ANALOG << 2;
	localparam logic [ADDR_W-1:0] ADDR_INPUTS = IDX_INPUTS << 2;
	localparam logic [ADDR_W-1:0] ADDR_OUTPUTS = IDX_OUTPUTS << 2;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h200;
	localparam logic [ADDR_W-1:0] ADDR_ISTAT = 12'h204;
	localparam logic [ADDR_W-1:0] ADDR_IMASK = 12'h208;
	localparam logic [ADDR_W-1:0] ADDR_CLAIM = 12'h20C;
	// ==========================================================
	// Field widths and positions.
	localparam int WARN_W = 6;
	localparam int IN_W = 8;
	localparam int OUT_W = 5;
	localparam int ADC_W = 16;
	localparam int NARROW_W = 14;
	localparam int CFG_IN_LSB = 0;
	localparam int CFG_APP_LSB = 8;
	localparam int CFG_INT_LSB = 16;
	localparam int CFG_VAR_LSB = 24;
	localparam int VAR_W = 2;
	localparam logic [DATA_W-1:0] CFG_WMASK = 32'h031F1FFF;
	localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] IMASK_RESET = 32'h00000000;
	// ==========================================================
	// Drive variants and the outputs each one has.
	localparam logic [VAR_W-1:0] VAR_FULL = 2'h0;
	localparam logic [VAR_W-1:0] VAR_FOUR = 2'h1;
	localparam logic [VAR_W-1:0] VAR_IFACE = 2'h2;
	localparam logic [OUT_W-1:0] OUTS_FULL = 5'h1F;
	localparam logic [OUT_W-1:0] OUTS_FOUR = 5'h0F;
	localparam logic [OUT_W-1:0] OUTS_IFACE = 5'h03;
endpackage

// file: core/drive_io_status_variables.sv
// Register bank for drive warnings, analog input and digital I/O.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Warning bits 0-3: heatsink, ambient, motor, calculated.
// - Warning bits 4,5: plus and minus overtravel.
// - Warnings word shows only active warnings.
// - Analog input signed, 8192 counts per ten volts.
// - Interface unit: 32768 counts per ten volts.
// - Inputs one to eight on bits 0-7.
// - Input bit one means input on.
// - Unassigned inputs always read zero.
// - Outputs read back on bits 0-4.
// - Written one turns output on, zero off.
// - Writes skip outputs not assigned to controller.
// - Controller value beats internal drive states.
// - Claimed outputs ignore writes; others still follow.
// - Full drive: output bits 5-31 undefined.
// - Four-output variant uses bits 0-3 only.
// - Interface unit has two outputs, bits 0-1.
module drive_io_status_variables #(
	parameter int NUM_IN = drive_io_pkg::IN_W,
	parameter int NUM_OUT = drive_io_pkg::OUT_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic [drive_io_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [drive_io_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [drive_io_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [drive_io_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [drive_io_pkg::WARN_W-1:0] warnPins,
	input wire logic [drive_io_pkg::IN_W-1:0] inputPins,
	input wire logic [drive_io_pkg::ADC_W-1:0] analogSample,
	input wire logic [drive_io_pkg::OUT_W-1:0] internalOutReq,
	input wire logic funcEnable,
	input wire logic funcDisable,
	input wire logic [drive_io_pkg::OUT_W-1:0] funcTarget,
	input wire logic [drive_io_pkg::OUT_W-1:0] funcLevel,
	output logic [drive_io_pkg::OUT_W-1:0] driveOut,
	output logic irq
);
	import drive_io_pkg::*;

	// ==========================================================
	// Elaboration checks.
	if (NUM_IN != IN_W)
	begin : gBadIn
		$error("Input count must match the inputs field");
	end
	if (NUM_OUT != OUT_W)
	begin : gBadOut
		$error("Output count must match the outputs field");
	end
	if (CFG_IN_LSB + IN_W > CFG_APP_LSB)
	begin : gBadInField
		$error("Input assignment field overlaps the next field");
	end
	if (CFG_APP_LSB + OUT_W > CFG_INT_LSB)
	begin : gBadAppField
		$error("Controller assignment field overlaps the next field");
	end
	if (CFG_INT_LSB + OUT_W > CFG_VAR_LSB)
	begin : gBadIntField
		$error("Internal assignment field overlaps the variant field");
	end
	if (CFG_VAR_LSB + VAR_W > DATA_W || NARROW_W > ADC_W)
	begin : gBadLayout
		$error("Variant or analog field does not fit its word");
	end

	// ==========================================================
	// Pin synchronisers.
	// Only the second stage and the warning third stage feed logic; the first may be metastable.
	logic [WARN_W-1:0] warnMeta_r;
	logic [WARN_W-1:0] warnSync_r;
	logic [WARN_W-1:0] warnPrev_r;
	logic [IN_W-1:0] inMeta_r;
	logic [IN_W-1:0] inSync_r;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			warnMeta_r <= '0;
			warnSync_r <= '0;
			warnPrev_r <= '0;
			inMeta_r <= '0;
			inSync_r <= '0;
		end
		else if (clkEn)
		begin
			warnMeta_r <= warnPins;
			warnSync_r <= warnMeta_r;
			warnPrev_r <= warnSync_r;
			inMeta_r <= inputPins;
			inSync_r <= inMeta_r;
		end
	end

	// ==========================================================
	// Configuration fields.
	logic [DATA_W-1:0] cfg_r;
	logic [IN_W-1:0] inAssign;
	logic [OUT_W-1:0] appAssign;
	logic [OUT_W-1:0] intAssign;
	logic [VAR_W-1:0] variant;
	logic [OUT_W-1:0] validOuts;
	logic ifaceUnit;

	assign inAssign = cfg_r[CFG_IN_LSB +: IN_W];
	assign appAssign = cfg_r[CFG_APP_LSB +: OUT_W];
	assign intAssign = cfg_r[CFG_INT_LSB +: OUT_W];
	assign variant = cfg_r[CFG_VAR_LSB +: VAR_W];
	assign ifaceUnit = (variant == VAR_IFACE);
	assign validOuts = (variant == VAR_FOUR) ? OUTS_FOUR :
		ifaceUnit ? OUTS_IFACE : OUTS_FULL;

	// ==========================================================
	// Status views.
	logic [DATA_W-1:0] warnWord;
	logic [DATA_W-1:0] inWord;
	logic [NARROW_W-1:0] narrow;
	logic [DATA_W-1:0] analog_r;
	logic [DATA_W-1:0] analog_nxt;

	// Pins carry the warning order directly; idle pins read zero.
	assign warnWord = {{(DATA_W-WARN_W){1'b0}}, warnSync_r};
	assign inWord = {{(DATA_W-IN_W){1'b0}}, inSync_r & inAssign};
	// The ADC is 16 bits; normal drives keep its top 14 bits.
	assign narrow = analogSample[ADC_W-1 -: NARROW_W];
	assign analog_nxt = ifaceUnit ?
		{{(DATA_W-ADC_W){analogSample[ADC_W-1]}}, analogSample} :
		{{(DATA_W-NARROW_W){narrow[NARROW_W-1]}}, narrow};

	// ==========================================================
	// Bus write channel.
	logic awHave_r;
	logic wHave_r;
	logic [ADDR_W-1:0] wrAddr_r;
	logic [DATA_W-1:0] wrData_r;
	logic [3:0] wrStrb_r;
	logic [DATA_W-1:0] strbMask;
	logic wrDo;
	logic wrOut;
	logic wrCfg;
	logic wrMask;
	logic wrMapped;

	assign strbMask = {{8{wrStrb_r[3]}}, {8{wrStrb_r[2]}},
		{8{wrStrb_r[1]}}, {8{wrStrb_r[0]}}};
	assign wrDo = awHave_r && wHave_r && !bvalid;
	assign wrOut = wrDo && (wrAddr_r == ADDR_OUTPUTS);
	assign wrCfg = wrDo && (wrAddr_r == ADDR_CONFIG);
	assign wrMask = wrDo && (wrAddr_r == ADDR_IMASK);
	assign wrMapped = (wrAddr_r == ADDR_WARN) ||
		(wrAddr_r == ADDR_ANALOG) || (wrAddr_r == ADDR_INPUTS) ||
		(wrAddr_r == ADDR_OUTPUTS) || (wrAddr_r == ADDR_CONFIG) ||
		(wrAddr_r == ADDR_ISTAT) || (wrAddr_r == ADDR_IMASK) ||
		(wrAddr_r == ADDR_CLAIM);

	// Ready stays low from the take until one edge after the response,
	// so a second write cannot land before the first is answered.

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			wrAddr_r <= '0;
			wrData_r <= '0;
			wrStrb_r <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (clkEn)
		begin
			awready <= !awHave_r && !(awvalid && awready);
			wready <= !wHave_r && !(wvalid && wready);
			if (awvalid && awready)
			begin
				awHave_r <= 1'b1;
				wrAddr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				wHave_r <= 1'b1;
				wrData_r <= wdata;
				wrStrb_r <= wstrb;
			end
			if (wrDo)
			begin
				bvalid <= 1'b1;
				bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Bus read channel.
	logic arTake;
	logic rdClr;
	logic [DATA_W-1:0] rdMux;
	logic [1:0] rdResp;
	logic [OUT_W-1:0] claim_r;
	logic [WARN_W-1:0] istat_r;
	logic [WARN_W-1:0] imask_r;

	assign arTake = arvalid && arready;
	// The clear lands at the take edge, after the mux has captured the
	// bits, so the read still returns every warning that it clears.
	assign rdClr = arTake && (araddr == ADDR_ISTAT);

	always_comb
	begin
		rdMux = '0;
		rdResp = RESP_OKAY;
		if (araddr == ADDR_WARN)
			rdMux = warnWord;
		else if (araddr == ADDR_ANALOG)
			rdMux = analog_r;
		else if (araddr == ADDR_INPUTS)
			rdMux = inWord;
		else if (araddr == ADDR_OUTPUTS)
			rdMux = {{(DATA_W-OUT_W){1'b0}}, driveOut};
		else if (araddr == ADDR_CONFIG)
			rdMux = cfg_r;
		else if (araddr == ADDR_ISTAT)
			rdMux = {{(DATA_W-WARN_W){1'b0}}, istat_r};
		else if (araddr == ADDR_IMASK)
			rdMux = {{(DATA_W-WARN_W){1'b0}}, imask_r};
		else if (araddr == ADDR_CLAIM)
			rdMux = {{(DATA_W-OUT_W){1'b0}}, claim_r};
		else
			rdResp = RESP_SLVERR;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else if (clkEn)
		begin
			if (arTake)
			begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rdMux;
				rresp <= rdResp;
			end
			else if (rvalid && rready)
			begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
			else if (!rvalid)
				arready <= 1'b1;
		end
	end

	// ==========================================================
	// Output ownership and pin drive.
	logic relArm_r;
	logic [OUT_W-1:0] claim_nxt;
	logic relArm_nxt;
	logic [OUT_W-1:0] appOut_r;
	logic [OUT_W-1:0] appWrEn;
	logic [OUT_W-1:0] appOut_nxt;
	logic [OUT_W-1:0] driveOut_nxt;

	// Running the function claims its target outputs. Holding the
	// disable with enable arms release; dropping enable then frees
	// them. Dropping enable without the disable keeps the claim.
	assign relArm_nxt = (funcEnable && funcDisable) ? 1'b1 :
		(!funcEnable) ? 1'b0 : relArm_r;
	assign claim_nxt = (funcEnable && !funcDisable) ?
		(claim_r | funcTarget) :
		(relArm_r && !funcEnable) ? '0 : claim_r;

	assign appWrEn = appAssign & ~claim_r & validOuts;
	assign appOut_nxt = wrOut ?
		((appOut_r & ~(appWrEn & strbMask[OUT_W-1:0])) |
		(wrData_r[OUT_W-1:0] & appWrEn & strbMask[OUT_W-1:0])) :
		appOut_r;

	// A pin assigned to nothing rests low.
	assign driveOut_nxt = validOuts & ((claim_r & funcLevel) |
		(~claim_r & appAssign & appOut_r) |
		(~claim_r & ~appAssign & intAssign & internalOutReq));

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			claim_r <= '0;
			relArm_r <= 1'b0;
			appOut_r <= '0;
			driveOut <= '0;
			analog_r <= '0;
		end
		else if (clkEn)
		begin
			claim_r <= claim_nxt;
			relArm_r <= relArm_nxt;
			appOut_r <= appOut_nxt;
			driveOut <= driveOut_nxt;
			analog_r <= analog_nxt;
		end
	end

	// ==========================================================
	// Configuration and interrupts.
	logic [WARN_W-1:0] warnRise;
	logic [WARN_W-1:0] istat_nxt;
	logic [DATA_W-1:0] cfg_nxt;
	logic [DATA_W-1:0] imaskWide;

	assign warnRise = warnSync_r & ~warnPrev_r;
	// A warning rising in the clearing read's cycle stays set.
	assign istat_nxt = (istat_r & ~{WARN_W{rdClr}}) | warnRise;
	assign cfg_nxt = (cfg_r & ~(strbMask & CFG_WMASK)) |
		(wrData_r & strbMask & CFG_WMASK);
	assign imaskWide = ({{(DATA_W-WARN_W){1'b0}}, imask_r} &
		~strbMask) | (wrData_r & strbMask);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_r <= CFG_RESET;
			imask_r <= IMASK_RESET[WARN_W-1:0];
			istat_r <= '0;
			irq <= 1'b0;
		end
		else if (clkEn)
		begin
			if (wrCfg)
				cfg_r <= cfg_nxt;
			if (wrMask)
				imask_r <= imaskWide[WARN_W-1:0];
			istat_r <= istat_nxt;
			irq <= |(istat_r & imask_r);
		end
	end
endmodule // drive_io_status_variables
`default_nettype wire

// file: dv/drive_io_status_variables_monitor.sv
// Bus handshake checker for the drive I/O register bank.
`timescale 1ns/10ps
`default_nettype none
module drive_io_status_variables_monitor (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [drive_io_pkg::DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	import drive_io_pkg::*;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Handshake properties.
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_write_answer: assert property (awvalid && awready && wvalid && wready
		&& clkEn |-> ##[1:4] bvalid)
		else $error("write response missing");
	a_read_answer: assert property (arvalid && arready && clkEn |=> rvalid)
		else $error("read response late");
	a_aw_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read accepted while response pending");
	a_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == '0)
		else $error("error read carries data");
	a_read_retire: assert property (rvalid && rready && clkEn |=> !rvalid)
		else $error("read response repeated");
endmodule // drive_io_status_variables_monitor
bind drive_io_status_variables drive_io_status_variables_monitor mon_u (
	.core_clk, .rst_b, .clkEn, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp,
	.rvalid, .rready);
`default_nettype wire

// file: dv/func_ctrl_model.sv
// Controller side model of the output claiming function's enables.
`timescale 1ns/10ps
`default_nettype none
module func_ctrl_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic claimReq,
	input wire logic releaseReq,
	output logic funcEnable,
	output logic funcDisable
);
	// A release raises enable with disable, then drops both.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			funcEnable <= 1'h0;
			funcDisable <= 1'h0;
		end
		else if (releaseReq)
		begin
			funcEnable <= 1'h1;
			funcDisable <= 1'h1;
		end
		else if (funcDisable)
		begin
			funcEnable <= 1'h0;
			funcDisable <= 1'h0;
		end
		else
			funcEnable <= claimReq;
	end
endmodule // func_ctrl_model
`default_nettype wire

// file: dv/drive_io_status_variables_tb_top.sv
// Self-checking bench for the drive I/O register bank.
`timescale 1ns/10ps
`default_nettype none
module drive_io_status_variables_tb_top;
	import drive_io_pkg::*;
	logic core_clk = 1'h0, rst_b = 1'h0, clkEn = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic rready = 1'h0, claimReq = 1'h0, releaseReq = 1'h0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [WARN_W-1:0] warnPins = '0;
	logic [IN_W-1:0] inputPins = '0;
	logic [ADC_W-1:0] analogSample = '0;
	logic [OUT_W-1:0] internalOutReq = '0, funcTarget = '0, funcLevel = '0;
	logic awready, wready, bvalid, arready, rvalid, funcEnable, funcDisable;
	logic irq;
	logic [1:0] bresp, rresp;
	logic [OUT_W-1:0] driveOut;
	logic [1:0] varCode [3] = '{2'h0, 2'h1, 2'h2};
	logic [4:0] outMask [3] = '{5'h1F, 5'h0F, 5'h03};
	logic [31:0] anaExp [3] = '{32'hFFFFE001, 32'hFFFFE001, 32'hFFFF8004};
	int mismatches = 0, compares = 0;
	always #10 core_clk = ~core_clk;
	drive_io_status_variables dut_u (.core_clk, .rst_b, .clkEn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .warnPins, .inputPins, .analogSample,
		.internalOutReq, .funcEnable, .funcDisable, .funcTarget,
		.funcLevel, .driveOut, .irq);
	func_ctrl_model model_u (.core_clk, .rst_b, .claimReq, .releaseReq,
		.funcEnable, .funcDisable);
	// ==========================================================
	// Tasks.
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic checkVal(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic giveUp(input int n);
		if (n >= 50)
		begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (awready === 1'h1)
				awvalid <= 1'h0;
			if (wready === 1'h1)
				wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1 && n < 50);
		giveUp(n);
		bready <= 1'h0;
		checkVal("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge core_clk);
	endtask
	task automatic readCheck(input string what, input logic [11:0] a,
		input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (arready === 1'h1)
				arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1 && n < 50);
		giveUp(n);
		rready <= 1'h0;
		checkVal(what, exp, rdata);
		checkVal("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge core_clk);
	endtask
	// ==========================================================
	// Main sequence.
	initial
	begin
		tick(10);
		rst_b <= 1'h1;
		tick(2);
		axiWrite(ADDR_CONFIG, 32'h00001F0F);
		inputPins <= 8'hA5;
		warnPins <= 6'h3F;
		tick(4);
		readCheck("inputs", ADDR_INPUTS, 32'h5, RESP_OKAY);
		readCheck("warn", ADDR_WARN, 32'h3F, RESP_OKAY);
		checkVal("irq masked", 32'h0, {31'h0, irq});
		readCheck("istat", ADDR_ISTAT, 32'h3F, RESP_OKAY);
		warnPins <= 6'h00;
		axiWrite(ADDR_WARN, 32'hFFFFFFFF);
		tick(3);
		readCheck("warn idle", ADDR_WARN, 32'h0, RESP_OKAY);
		readCheck("unmapped", 12'h300, 32'h0, RESP_SLVERR);
		axiWrite(12'h300, 32'h0, RESP_SLVERR);
		axiWrite(ADDR_IMASK, 32'h2);
		warnPins <= 6'h02;
		tick(6);
		checkVal("irq set", 32'h1, {31'h0, irq});
		readCheck("istat", ADDR_ISTAT, 32'h2, RESP_OKAY);
		tick(3);
		checkVal("irq clear", 32'h0, {31'h0, irq});
		analogSample <= 16'h8004;
		for (int v = 0; v < 3; v++)
		begin
			axiWrite(ADDR_CONFIG, {6'h0, varCode[v], 24'h001F00});
			axiWrite(ADDR_OUTPUTS, 32'hFFFFFFFF);
			tick(3);
			readCheck("outs", ADDR_OUTPUTS, {27'h0, outMask[v]}, RESP_OKAY);
			checkVal("pins", {27'h0, outMask[v]}, {27'h0, driveOut});
			readCheck("analog", ADDR_ANALOG, anaExp[v], RESP_OKAY);
		end
		axiWrite(ADDR_CONFIG, 32'h001F0F00);
		internalOutReq <= 5'h1F;
		axiWrite(ADDR_OUTPUTS, 32'h0);
		tick(3);
		checkVal("priority", 32'h10, {27'h0, driveOut});
		axiWrite(ADDR_CONFIG, 32'h00001F00);
		funcTarget <= 5'h03;
		funcLevel <= 5'h01;
		claimReq <= 1'h1;
		tick(3);
		tick(1);
		checkVal("kept", 32'h11, {27'h0, driveOut});
		axiWrite(ADDR_OUTPUTS, 32'h1E);
		tick(3);
		checkVal("claimed", 32'h1D, {27'h0, driveOut});
		readCheck("claim", ADDR_CLAIM, 32'h3, RESP_OKAY);
		claimReq <= 1'h0;
		releaseReq <= 1'h1;
		tick(1);
		releaseReq <= 1'h0;
		tick(4);
		axiWrite(ADDR_OUTPUTS, 32'h02);
		tick(3);
		checkVal("released", 32'h02, {27'h0, driveOut});
		clkEn <= 1'h0;
		claimReq <= 1'h1;
		tick(4);
		checkVal("frozen", 32'h02, {27'h0, driveOut});
		clkEn <= 1'h1;
		tick(4);
		checkVal("thawed", 32'h01, {27'h0, driveOut});
		finish_test();
	end
endmodule // drive_io_status_variables_tb_top
`default_nettype wire
